/* hdl/optcfg_pkg.sv */
// Constants, field layout and state codes for the option byte decoder
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`default_nettype none
package optcfg_pkg;
    // Defaults of the non-volatile bytes
    localparam logic [7:0] OPT0_DEFAULT = 8'hfc;
    localparam logic [7:0] OPT1_DEFAULT = 8'h3f;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    // Option byte 1 layout
    localparam int STARTUP_CLK_MSB = 7;
    localparam int STARTUP_CLK_LSB = 6;
    localparam int BOR_MSB = 3;
    localparam int BOR_LSB = 2;
    localparam int WDG_TYPE_BIT = 1;
    localparam int HALT_RST_BIT = 0;
    // Option byte 0 layout
    localparam int WAKE_CLK_BIT = 7;
    localparam int RANGE_MSB = 6;
    localparam int RANGE_LSB = 4;
    localparam int SECTOR_MSB = 3;
    localparam int SECTOR_LSB = 2;
    localparam int RDP_BIT = 1;
    localparam int WRP_BIT = 0;
    // Encodings
    localparam logic [1:0] STARTUP_INT_RC = 2'h0;
    localparam logic [1:0] BOR_OFF = 2'h3;
    localparam logic [12:0] SECTOR_BASE_BYTES = 13'h200;
    localparam int STARTUP_DELAY_CYCLES = 256;
    // Controller states
    typedef enum logic [2:0] {
        CTL_LOAD = 3'h1,
        CTL_RUN = 3'h2,
        CTL_WIPE = 3'h4
    } ctl_state_e;
endpackage
`default_nettype wire

/* hdl/opt_port_if.sv */
// Interface between the option byte controller and its byte store
`timescale 1ns/100ps
`default_nettype none
interface opt_port_if;
    logic we;
    logic sel;
    logic erase;
    logic [7:0] wdata;
    logic [7:0] byte0;
    logic [7:0] byte1;
    modport ctrl (output we, output sel, output erase, output wdata,
                  input byte0, input byte1);
    modport store (input we, input sel, input erase, input wdata,
                   output byte0, output byte1);
endinterface
`default_nettype wire

/* hdl/opt_store.sv */
// Two-byte option store with registered read data
`timescale 1ns/100ps
`default_nettype none
module opt_store
    import optcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    opt_port_if.store port
);
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
    } store_s;

    store_s s_ff;
    store_s nxt_s;

    // ------------------------------------------------------------
    // Byte update
    // ------------------------------------------------------------
    // Erase restores the delivered defaults; write hits one byte
    always_comb begin
        nxt_s = s_ff;
        if (port.erase) begin
            nxt_s.b0 = OPT0_DEFAULT;
            nxt_s.b1 = OPT1_DEFAULT;
        end else if (port.we) begin
            if (port.sel) begin
                nxt_s.b1 = port.wdata;
            end else begin
                nxt_s.b0 = port.wdata;
            end
        end
    end

    // Reset stands in for the power-on load of the cells
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_ff.b0 <= OPT0_DEFAULT;
            s_ff.b1 <= OPT1_DEFAULT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign port.byte0 = s_ff.b0;
    assign port.byte1 = s_ff.b1;

    a_erase_defaults: assert property (@(posedge clk) disable iff (!rstn)
        port.erase |=> (s_ff.b0 == OPT0_DEFAULT && s_ff.b1 == OPT1_DEFAULT))
        else $error("erase did not restore defaults");
endmodule // opt_store
`default_nettype wire

/* hdl/option_byte_config_decoder.sv */
// Option byte controller: programming access, protection and decode
`timescale 1ns/100ps
`default_nettype none
module option_byte_config_decoder
    import optcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic prog_mode,
    input wire logic prog_req,
    input wire logic prog_write,
    input wire logic prog_erase,
    input wire logic prog_sel,
    input wire logic [7:0] prog_wdata,
    input wire logic mem_erase_done,
    output logic [7:0] prog_rdata,
    output logic prog_ack,
    output logic prog_refused,
    output logic mem_erase_all,
    output logic [7:0] mem_fill_data,
    output logic flash_write_allow,
    output logic readout_block,
    output logic [1:0] startup_clock_select,
    output logic startup_delay_256,
    output logic [2:0] oscillator_range,
    output logic resonator_range_valid,
    output logic wakeup_clock_select,
    output logic [1:0] brownout_threshold_select,
    output logic brownout_enable,
    output logic watchdog_type_select,
    output logic watchdog_hw_enable,
    output logic halt_watchdog_reset,
    output logic [1:0] boot_sector_size,
    output logic [12:0] sector0_bytes,
    output logic readout_protect,
    output logic write_protect
);
    typedef struct packed {
        ctl_state_e state;
        logic mode_s1, mode_s2;
        logic req_s1, req_s2, req_d;
        logic wr_s1, wr_s2;
        logic er_s1, er_s2;
        logic sel_s1, sel_s2;
        logic [7:0] dat_s1, dat_s2;
        logic [7:0] rdata;
        logic ack, refused, wipe, wipe_sel;
        logic [1:0] clk_sel;
        logic dly256;
        logic [2:0] range;
        logic range_ok, wake_clk;
        logic [1:0] bor;
        logic bor_en, wdg_type, wdg_hw, halt_rst;
        logic [1:0] sector;
        logic [12:0] sector_bytes;
        logic rdp, wrp, fwa;
    } ctl_s;

    ctl_s s_ff;
    ctl_s nxt_s;
    opt_port_if port ();
    logic take;

    opt_store u_store (
        .clk(clk),
        .rstn(rstn),
        .port(port.store)
    );

    // ------------------------------------------------------------
    // Request path and decode
    // ------------------------------------------------------------
    // Tool pins pass two flops; a request is the rise of prog_req
    assign take = s_ff.req_s2 & ~s_ff.req_d;

    always_comb begin
        nxt_s = s_ff;
        port.we = 1'b0;
        port.erase = 1'b0;
        port.sel = s_ff.sel_s2;
        port.wdata = s_ff.dat_s2;
        nxt_s.mode_s1 = prog_mode;
        nxt_s.mode_s2 = s_ff.mode_s1;
        nxt_s.req_s1 = prog_req;
        nxt_s.req_s2 = s_ff.req_s1;
        nxt_s.req_d = s_ff.req_s2;
        nxt_s.wr_s1 = prog_write;
        nxt_s.wr_s2 = s_ff.wr_s1;
        nxt_s.er_s1 = prog_erase;
        nxt_s.er_s2 = s_ff.er_s1;
        nxt_s.sel_s1 = prog_sel;
        nxt_s.sel_s2 = s_ff.sel_s1;
        nxt_s.dat_s1 = prog_wdata;
        nxt_s.dat_s2 = s_ff.dat_s1;
        nxt_s.ack = 1'b0;
        nxt_s.refused = 1'b0;
        unique case (s_ff.state)
            // Decode once after reset; never again until the next one
            CTL_LOAD: begin
                nxt_s.clk_sel =
                    port.byte1[STARTUP_CLK_MSB:STARTUP_CLK_LSB];
                nxt_s.dly256 = (port.byte1[STARTUP_CLK_MSB:STARTUP_CLK_LSB]
                                == STARTUP_INT_RC);
                nxt_s.range_ok = port.byte1[STARTUP_CLK_MSB];
                nxt_s.range = port.byte0[RANGE_MSB:RANGE_LSB];
                nxt_s.wake_clk = port.byte0[WAKE_CLK_BIT];
                nxt_s.bor = port.byte1[BOR_MSB:BOR_LSB];
                nxt_s.bor_en = (port.byte1[BOR_MSB:BOR_LSB] != BOR_OFF);
                nxt_s.wdg_type = port.byte1[WDG_TYPE_BIT];
                nxt_s.wdg_hw = ~port.byte1[WDG_TYPE_BIT];
                nxt_s.halt_rst = port.byte1[HALT_RST_BIT];
                nxt_s.sector = port.byte0[SECTOR_MSB:SECTOR_LSB];
                nxt_s.sector_bytes = SECTOR_BASE_BYTES
                                     << port.byte0[SECTOR_MSB:SECTOR_LSB];
                nxt_s.rdp = port.byte0[RDP_BIT];
                nxt_s.wrp = port.byte0[WRP_BIT];
                // Registered so the flash unit sees a clean level
                nxt_s.fwa = ~port.byte0[RDP_BIT]
                            & ~port.byte0[WRP_BIT];
                nxt_s.state = CTL_RUN;
            end
            CTL_RUN: begin
                if (take) begin
                    if (!s_ff.mode_s2) begin
                        nxt_s.refused = 1'b1;
                    end else if (!s_ff.wr_s2 && !s_ff.er_s2) begin
                        nxt_s.rdata = s_ff.sel_s2 ? port.byte1 : port.byte0;
                        nxt_s.ack = 1'b1;
                    end else if (port.byte0[WRP_BIT]) begin
                        // Live bit: a protect set this session holds at once
                        nxt_s.refused = 1'b1;
                    end else if (s_ff.er_s2 && port.byte0[RDP_BIT]) begin
                        nxt_s.wipe = 1'b1;
                        nxt_s.state = CTL_WIPE;
                    end else begin
                        port.erase = s_ff.er_s2;
                        port.we = ~s_ff.er_s2;
                        nxt_s.ack = 1'b1;
                    end
                end
            end
            // Whole memory goes blank before the option bytes may clear
            CTL_WIPE: begin
                if (mem_erase_done) begin
                    nxt_s.wipe = 1'b0;
                    port.erase = 1'b1;
                    nxt_s.ack = 1'b1;
                    nxt_s.state = CTL_RUN;
                end
            end
        endcase
    end

    // Reset loads the decode of the default bytes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_ff <= '0;
            s_ff.state <= CTL_LOAD;
            s_ff.clk_sel <=
                OPT1_DEFAULT[STARTUP_CLK_MSB:STARTUP_CLK_LSB];
            s_ff.dly256 <= 1'b1;
            s_ff.range <= OPT0_DEFAULT[RANGE_MSB:RANGE_LSB];
            s_ff.wake_clk <= OPT0_DEFAULT[WAKE_CLK_BIT];
            s_ff.bor <= OPT1_DEFAULT[BOR_MSB:BOR_LSB];
            s_ff.wdg_type <= OPT1_DEFAULT[WDG_TYPE_BIT];
            s_ff.halt_rst <= OPT1_DEFAULT[HALT_RST_BIT];
            s_ff.sector <= OPT0_DEFAULT[SECTOR_MSB:SECTOR_LSB];
            s_ff.sector_bytes <= SECTOR_BASE_BYTES
                                 << OPT0_DEFAULT[SECTOR_MSB:SECTOR_LSB];
            s_ff.fwa <= ~OPT0_DEFAULT[RDP_BIT] & ~OPT0_DEFAULT[WRP_BIT];
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state register, except mem_fill_data, which is the constant BLANK_BYTE
    // ------------------------------------------------------------
    assign prog_rdata = s_ff.rdata;
    assign prog_ack = s_ff.ack;
    assign prog_refused = s_ff.refused;
    assign mem_erase_all = s_ff.wipe;
    assign mem_fill_data = BLANK_BYTE;
    assign flash_write_allow = s_ff.fwa;
    assign readout_block = s_ff.rdp;
    assign startup_clock_select = s_ff.clk_sel;
    assign startup_delay_256 = s_ff.dly256;
    assign oscillator_range = s_ff.range;
    assign resonator_range_valid = s_ff.range_ok;
    assign wakeup_clock_select = s_ff.wake_clk;
    assign brownout_threshold_select = s_ff.bor;
    assign brownout_enable = s_ff.bor_en;
    assign watchdog_type_select = s_ff.wdg_type;
    assign watchdog_hw_enable = s_ff.wdg_hw;
    assign halt_watchdog_reset = s_ff.halt_rst;
    assign boot_sector_size = s_ff.sector;
    assign sector0_bytes = s_ff.sector_bytes;
    assign readout_protect = s_ff.rdp;
    assign write_protect = s_ff.wrp;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_refuse_outside_mode: assert property (@(posedge clk) disable iff (!rstn)
        (s_ff.state == CTL_RUN && take && !s_ff.mode_s2)
        |=> (prog_refused && !prog_ack)) else $error("access outside mode");
    a_wp_refuses_all: assert property (@(posedge clk) disable iff (!rstn)
        (s_ff.state == CTL_RUN && take && s_ff.mode_s2 && port.byte0[WRP_BIT]
         && (s_ff.wr_s2 || s_ff.er_s2))
        |-> (!port.we && !port.erase) ##1 prog_refused)
        else $error("write protect ignored");
    a_wipe_first: assert property (@(posedge clk) disable iff (!rstn)
        (s_ff.state == CTL_WIPE && !mem_erase_done) |-> !port.erase ##1
        mem_erase_all) else $error("bytes erased before memory");
    a_cfg_latch: assert property (@(posedge clk) disable iff (!rstn)
        (s_ff.state == CTL_LOAD) |=> (startup_clock_select ==
        $past(port.byte1[STARTUP_CLK_MSB:STARTUP_CLK_LSB]) &&
        halt_watchdog_reset ==
        $past(port.byte1[HALT_RST_BIT]))) else $error("latch wrong");
    a_cfg_stable: assert property (@(posedge clk) disable iff (!rstn)
        (s_ff.state != CTL_LOAD && $past(s_ff.state) != CTL_LOAD
         && $past(rstn))
        |-> ($stable(oscillator_range) && $stable(write_protect)))
        else $error("config moved");
    a_sector_size: assert property (@(posedge clk) disable iff (!rstn)
        sector0_bytes == (SECTOR_BASE_BYTES << boot_sector_size))
        else $error("sector size");
    a_bor_enable: assert property (@(posedge clk) disable iff (!rstn)
        brownout_enable == (brownout_threshold_select != BOR_OFF))
        else $error("brownout enable");
    a_wdg_mode: assert property (@(posedge clk) disable iff (!rstn)
        (watchdog_hw_enable != watchdog_type_select) &&
        (resonator_range_valid == startup_clock_select[1]))
        else $error("watchdog or range gate");
    a_rc_delay: assert property (@(posedge clk) disable iff (!rstn)
        startup_delay_256 == (startup_clock_select == STARTUP_INT_RC))
        else $error("startup delay");
endmodule // option_byte_config_decoder
`default_nettype wire

/* tb/prog_tool_model.sv */
// Programming tool model driving the option programming pins
`timescale 1ns/100ps
`default_nettype none
module prog_tool_model (
    input wire logic clk,
    input wire logic prog_ack,
    input wire logic prog_refused,
    input wire logic [7:0] prog_rdata,
    output logic prog_mode,
    output logic prog_req,
    output logic prog_write,
    output logic prog_erase,
    output logic prog_sel,
    output logic [7:0] prog_wdata
);
    logic [1:0] clk_sel_last;
    // Pins idle at time zero
    initial begin
        prog_mode = 1'b0;
        prog_req = 1'b0;
        prog_write = 1'b0;
        prog_erase = 1'b0;
        prog_sel = 1'b0;
        prog_wdata = 8'h5a;
        clk_sel_last = 2'h0;
    end
    // Mode pin is synchronised inside, so let it settle before use
    task automatic set_mode(input logic m);
        @(posedge clk);
        #1 prog_mode = m;
        repeat (4) @(posedge clk);
    endtask
    // One request; pins held until the answer is sampled
    task automatic xfer(input logic w, input logic e, input logic s,
                        input logic [7:0] d, output logic [1:0] res,
                        output logic [7:0] rd, output logic stood);
        logic [7:0] v;
        v = d;
        if (w && s) v[5:4] = 2'h3;
        if (w && !s && !v[7]) v[6:4] = 3'h4;
        else if (w && !s && clk_sel_last == 2'h0) v[6:4] = 3'h7;
        if (w && s) clk_sel_last = v[7:6];
        res = 2'h0;
        rd = 8'h00;
        @(posedge clk);
        #1;
        prog_write = w;
        prog_erase = e;
        prog_sel = s;
        prog_wdata = v;
        @(posedge clk);
        #1 prog_req = 1'b1;
        // Answer is read just after its edge, once the outputs settled
        for (int i = 0; i < 40 && res == 2'h0; i++) begin
            @(posedge clk);
            #1;
            rd = prog_rdata;
            if (prog_ack === 1'b1) res = 2'h1;
            else if (prog_refused === 1'b1) res = 2'h2;
        end
        prog_req = 1'b0;
        prog_wdata = ~v; // Released data shows junk, not the last byte
        @(posedge clk);
        #1 stood = (prog_ack !== 1'b0) || (prog_refused !== 1'b0);
        repeat (3) @(posedge clk);
    endtask
endmodule // prog_tool_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the option byte decoder
`timescale 1ns/100ps
`default_nettype none
module tb
    import optcfg_pkg::*;
();
    logic clk, rstn, req, wr, er, sel, mode, ack, refd, erase_all;
    logic done = 1'b0;
    logic fwa, rblk, dly, rvalid, wake, bor_en, wtype, whw, halt, rdp, wrp;
    logic [7:0] wdata, rdata, fill;
    logic [2:0] range;
    logic [2:0] wipe_cnt = 3'h0;
    logic [1:0] clk_sel, bor, sector_sz, res;
    logic [12:0] s0b;
    logic stood;
    int wipe_events = 0;
    logic [7:0] rd;
    int fail_count = 0;
    int samples_checked = 0;

    // ---------------------------------------------
    // Clock, flash unit stand-in and instances
    // ---------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Flash answers a full erase after a few cycles, stalling on purpose;
    // each erase is counted once, in its first cycle
    always @(posedge clk) begin
        #1;
        wipe_cnt = (erase_all === 1'b1) ? wipe_cnt + 3'h1 : 3'h0;
        done = (wipe_cnt == 3'h5);
        if (wipe_cnt == 3'h1) wipe_events = wipe_events + 1;
    end
    prog_tool_model tool (.clk(clk), .prog_ack(ack), .prog_refused(refd),
        .prog_rdata(rdata), .prog_mode(mode), .prog_req(req),
        .prog_write(wr), .prog_erase(er), .prog_sel(sel),
        .prog_wdata(wdata));
    option_byte_config_decoder dut (.clk(clk), .rstn(rstn),
        .prog_mode(mode), .prog_req(req), .prog_write(wr),
        .prog_erase(er), .prog_sel(sel), .prog_wdata(wdata),
        .mem_erase_done(done), .prog_rdata(rdata), .prog_ack(ack),
        .prog_refused(refd), .mem_erase_all(erase_all),
        .mem_fill_data(fill), .flash_write_allow(fwa),
        .readout_block(rblk), .startup_clock_select(clk_sel),
        .startup_delay_256(dly), .oscillator_range(range),
        .resonator_range_valid(rvalid), .wakeup_clock_select(wake),
        .brownout_threshold_select(bor), .brownout_enable(bor_en),
        .watchdog_type_select(wtype), .watchdog_hw_enable(whw),
        .halt_watchdog_reset(halt), .boot_sector_size(sector_sz),
        .sector0_bytes(s0b), .readout_protect(rdp), .write_protect(wrp));

    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Request through the tool; a lost answer ends the run
    task automatic req_do(input logic w, e, s, input logic [7:0] d,
                          input logic [1:0] exp);
        tool.xfer(w, e, s, d, res, rd, stood);
        check("answer", res, exp);
        check("answer length", stood, 1'b0);
        if (res == 2'h0) end_sim();
    endtask
    task automatic reset_dut;
        #1 rstn = 1'b0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    // Defaults of fc/3f appear on the decoded outputs
    task automatic t_defaults;
        check("clock select", clk_sel, 2'h0);
        check("delay", {dly, rvalid}, 2'h2);
        check("range", {range, wake}, 4'hf);
        check("bor", {bor, bor_en}, 3'h6);
        check("wdg", {wtype, whw}, 2'h2);
        check("halt", halt, 1'b1);
        check("sector", {sector_sz, s0b}, {2'h3, 13'h1000});
        check("prot", {rdp, wrp, rblk, fwa}, 4'h1);
        check("fill", fill, 8'hff);
    endtask
    // Without programming mode every request is refused
    task automatic t_no_mode;
        tool.set_mode(1'b0);
        req_do(1'b0, 1'b0, 1'b0, 8'h00, 2'h2);
        req_do(1'b1, 1'b0, 1'b1, 8'h00, 2'h2);
    endtask
    // Writes land in the store but decoded values stay latched
    task automatic t_rw;
        tool.set_mode(1'b1);
        req_do(1'b1, 1'b0, 1'b1, 8'h42, 2'h1);
        req_do(1'b0, 1'b0, 1'b1, 8'h00, 2'h1);
        check("byte1", rd, 8'h42 | 8'h30);
        req_do(1'b0, 1'b0, 1'b0, 8'h00, 2'h1);
        check("byte0", rd, OPT0_DEFAULT);
        req_do(1'b1, 1'b0, 1'b0, 8'h0c, 2'h1);
        req_do(1'b0, 1'b0, 1'b0, 8'h00, 2'h1);
        check("byte0 wake", rd, 8'h4c);
        check("latched", {clk_sel, wake, s0b},
              {2'h0, 1'b1, 13'h1000});
    endtask
    // Write protect refuses writes and erase, reads still allowed
    task automatic t_wrp;
        req_do(1'b1, 1'b0, 1'b0, 8'hfd, 2'h1);
        req_do(1'b1, 1'b0, 1'b0, 8'hfc, 2'h2);
        req_do(1'b1, 1'b0, 1'b1, 8'h3f, 2'h2);
        req_do(1'b0, 1'b1, 1'b0, 8'h00, 2'h2);
        req_do(1'b0, 1'b0, 1'b0, 8'h00, 2'h1);
        check("wrp byte0", rd, 8'hfd);
        check("wrp latched", {wrp, fwa}, 2'h1);
    endtask
    // Erase under read-out protect wipes memory first
    task automatic t_rdp;
        int n;
        reset_dut();
        tool.set_mode(1'b1);
        req_do(1'b1, 1'b0, 1'b0, 8'hfe, 2'h1);
        n = wipe_events;
        req_do(1'b0, 1'b1, 1'b0, 8'h00, 2'h1);
        check("wipe", 16'(wipe_events - n), 16'h0001);
        req_do(1'b0, 1'b0, 1'b0, 8'h00, 2'h1);
        check("erased byte0", rd, OPT0_DEFAULT);
        req_do(1'b0, 1'b0, 1'b1, 8'h00, 2'h1);
        check("erased byte1", rd, OPT1_DEFAULT);
        n = wipe_events;
        req_do(1'b0, 1'b1, 1'b0, 8'h00, 2'h1);
        check("no wipe", 16'(wipe_events - n), 16'h0000);
    endtask

    initial begin
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clk);
        t_defaults();
        t_no_mode();
        t_rw();
        t_wrp();
        t_rdp();
        t_defaults();
        end_sim();
    end
endmodule // tb
`default_nettype wire
